// *** rtl/switch_port_interrupt_gen.sv ***
// Functional notes
// - Unmasked assertion with MSI enabled sends an MSI; negation sends nothing.
// - MSI off, legacy enabled: assertion sends an assert-INTA request.
// - MSI off, legacy enabled: negation sends a deassert-INTA request.
// - Condition ends once every causing status bit is masked or cleared.
// - Every MSI is treated as root-bound and sent to the upstream port.
// - Sources: hot-plug controller and enabled bandwidth status bits.
// - Legacy messages use pin A only, never B, C or D.
// - Link down or partition removal negates the legacy virtual wire.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module switch_port_interrupt_gen (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        clock_en,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic        hotplug_intr,
	input  wire logic        link_bw_mgmt_status,
	input  wire logic        link_autonomous_bw_status,
	input  wire logic        link_up,
	input  wire logic        in_partition,
	output logic             msi_req,
	output logic      [63:0] msi_addr,
	output logic      [15:0] msi_data,
	input  wire logic        msi_ack,
	output logic             intx_req,
	output logic             intx_assert,
	output logic      [1:0]  intx_pin,
	output logic             intx_wire,
	output logic             cond_level
);
	typedef struct packed {
		logic        msi_enable;
		logic        legacy_intr_disable;
		logic        bw_notify;
		logic        abw_notify;
		logic        hp_enable;
		logic [31:0] msi_addr_low;
		logic [31:0] msi_addr_high;
		logic [15:0] msi_data;
		logic [1:0]  bw_sync1;
		logic [1:0]  bw_sync2;
		logic [1:0]  hp_sync;
		logic [1:0]  link_sync;
		logic        cond;
		logic        msi_pend;
		logic        msi_req;
		logic        intx_req;
		logic        intx_assert;
		logic [7:0]  msi_count;
		logic [31:0] rdata;
	} top_state_type;

	top_state_type st_reg;
	top_state_type st_next;
	logic          bw_live;
	logic          abw_live;
	logic          cond_now;
	logic          link_down;

	intr_req_if edge_bus ();

	intr_edge_detect u_edge (
		.clock  (clock),
		.rstn   (rstn),
		.enable (clock_en),
		.bus    (edge_bus)
	);

	// Synchronised pin levels
	assign bw_live   = st_reg.bw_sync2[intr_gen_pkg::bw_status_bit];
	assign abw_live  = st_reg.bw_sync2[intr_gen_pkg::abw_status_bit];
	assign link_down = !(st_reg.link_sync[1]);
	// Combined condition: drops when all causing bits are masked or cleared
	assign cond_now  = (st_reg.hp_enable && st_reg.hp_sync[1])
		|| (st_reg.bw_notify && bw_live)
		|| (st_reg.abw_notify && abw_live);

	// Feed the edge detector
	assign edge_bus.cond       = st_reg.cond;
	assign edge_bus.msi_en     = st_reg.msi_enable;
	assign edge_bus.legacy_dis = st_reg.legacy_intr_disable;
	assign edge_bus.link_down  = link_down;

	// Next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.bw_sync1 = {link_autonomous_bw_status, link_bw_mgmt_status};
		st_next.bw_sync2 = st_reg.bw_sync1;
		st_next.hp_sync = {st_reg.hp_sync[0], hotplug_intr};
		st_next.link_sync = {st_reg.link_sync[0], link_up && in_partition};
		st_next.cond = cond_now;
		st_next.intx_req = 1'b0;
		st_next.msi_req = st_reg.msi_req && !msi_ack;
		st_next.rdata = 32'h0000_0000;
		// MSI on assertion whatever legacy disable holds
		if (edge_bus.rise && st_reg.msi_enable) begin
			st_next.msi_pend = 1'b1;
		end
		// Route every MSI upstream as a root-bound write
		if (st_next.msi_pend && !st_next.msi_req) begin
			st_next.msi_req = 1'b1;
			st_next.msi_pend = 1'b0;
			st_next.msi_count = st_reg.msi_count + 8'h01;
		end
		// Legacy requests on transitions only
		if (link_down && edge_bus.wire_level) begin
			st_next.intx_req = 1'b1;
			st_next.intx_assert = 1'b0;
		end else if (!st_reg.msi_enable && !st_reg.legacy_intr_disable && !link_down) begin
			if (edge_bus.rise) begin
				st_next.intx_req = 1'b1;
				st_next.intx_assert = 1'b1;
			end else if (edge_bus.fall && edge_bus.wire_level) begin
				st_next.intx_req = 1'b1;
				st_next.intx_assert = 1'b0;
			end
		end
		// Register writes
		if (reg_write) begin
			unique case (reg_addr)
				intr_gen_pkg::ctrl_offset: begin
					st_next.msi_enable = reg_wdata[intr_gen_pkg::msi_enable_bit];
					st_next.legacy_intr_disable = reg_wdata[intr_gen_pkg::legacy_dis_bit];
					st_next.bw_notify = reg_wdata[intr_gen_pkg::bw_notify_bit];
					st_next.abw_notify = reg_wdata[intr_gen_pkg::abw_notify_bit];
					st_next.hp_enable = reg_wdata[intr_gen_pkg::hp_enable_bit];
				end
				intr_gen_pkg::addr_low_offset: begin
					st_next.msi_addr_low = reg_wdata;
				end
				intr_gen_pkg::addr_high_offset: begin
					st_next.msi_addr_high = reg_wdata;
				end
				intr_gen_pkg::data_offset: begin
					st_next.msi_data = reg_wdata[15:0];
				end
				default: begin
				end
			endcase
		end
		// Register reads, data in the next cycle
		if (reg_read) begin
			unique case (reg_addr)
				intr_gen_pkg::ctrl_offset: begin
					st_next.rdata = {27'h0, st_reg.hp_enable, st_reg.abw_notify,
						st_reg.bw_notify, st_reg.legacy_intr_disable, st_reg.msi_enable};
				end
				intr_gen_pkg::status_offset: begin
					st_next.rdata = {26'h0, st_reg.link_sync[1], edge_bus.wire_level,
						st_reg.cond, st_reg.hp_sync[1], abw_live, bw_live};
				end
				intr_gen_pkg::addr_low_offset: begin
					st_next.rdata = st_reg.msi_addr_low;
				end
				intr_gen_pkg::addr_high_offset: begin
					st_next.rdata = st_reg.msi_addr_high;
				end
				intr_gen_pkg::data_offset: begin
					st_next.rdata = {16'h0, st_reg.msi_data};
				end
				intr_gen_pkg::count_offset: begin
					st_next.rdata = {24'h0, st_reg.msi_count};
				end
				default: begin
					st_next.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_reg <= '0;
		end else if (clock_en) begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops, except the constant pin code
	assign reg_rdata   = st_reg.rdata;
	assign msi_req     = st_reg.msi_req;
	assign msi_addr    = {st_reg.msi_addr_high, st_reg.msi_addr_low};
	assign msi_data    = st_reg.msi_data;
	assign intx_req    = st_reg.intx_req;
	assign intx_assert = st_reg.intx_assert;
	assign intx_pin    = intr_gen_pkg::pin_a_code;
	assign intx_wire   = edge_bus.wire_level;
	assign cond_level  = st_reg.cond;

	// Assertion sequences: request kinds and enabled sources
	sequence rise_msi_s;
		edge_bus.rise && st_reg.msi_enable && clock_en;
	endsequence

	sequence rise_legacy_s;
		edge_bus.rise && !st_reg.msi_enable && !st_reg.legacy_intr_disable && !link_down;
	endsequence

	sequence legacy_assert_s;
		intx_req && intx_assert;
	endsequence

	sequence legacy_deassert_s;
		intx_req && !intx_assert;
	endsequence

	sequence hp_source_s;
		st_reg.hp_enable && st_reg.hp_sync[1] && clock_en;
	endsequence

	sequence masked_all_s;
		!st_reg.hp_enable && !st_reg.bw_notify && !st_reg.abw_notify && clock_en;
	endsequence

	// Message path
	msi_on_rise_a: assert property (@(posedge clock) disable iff (!rstn)
		rise_msi_s |-> ##[1:3] msi_req) else $error("no msi after rise");

	no_legacy_msi_a: assert property (@(posedge clock) disable iff (!rstn)
		st_reg.msi_enable && !link_down && !edge_bus.wire_level && clock_en |=> !intx_req)
		else $error("legacy req while msi on");

	msi_source_a: assert property (@(posedge clock) disable iff (!rstn)
		$rose(msi_req) |-> $past(st_reg.msi_pend || (edge_bus.rise && st_reg.msi_enable)))
		else $error("msi without a cause");

	msi_held_a: assert property (@(posedge clock) disable iff (!rstn)
		msi_req && !msi_ack && clock_en |=> msi_req) else $error("msi dropped before ack");

	msi_count_a: assert property (@(posedge clock) disable iff (!rstn)
		$rose(msi_req) |-> st_reg.msi_count == $past(st_reg.msi_count) + 8'h01)
		else $error("msi not counted");

	// Legacy requests
	assert_req_a: assert property (@(posedge clock) disable iff (!rstn)
		rise_legacy_s and clock_en |=> intx_req && intx_assert) else $error("no assert req");

	deassert_req_a: assert property (@(posedge clock) disable iff (!rstn)
		edge_bus.fall && edge_bus.wire_level && !link_down && !st_reg.msi_enable
		&& !st_reg.legacy_intr_disable |=> intx_req && !intx_assert)
		else $error("no deassert req");

	wire_on_assert_a: assert property (@(posedge clock) disable iff (!rstn)
		legacy_assert_s |-> intx_wire) else $error("wire low on assert");

	wire_off_deassert_a: assert property (@(posedge clock) disable iff (!rstn)
		legacy_deassert_s |-> !intx_wire) else $error("wire high on deassert");

	legacy_dis_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
		st_reg.legacy_intr_disable && !edge_bus.wire_level && clock_en |=> !intx_req)
		else $error("legacy req while disabled");

	no_repeat_a: assert property (@(posedge clock) disable iff (!rstn)
		intx_req && intx_assert |=> !(intx_req && intx_assert)) else $error("repeat assert");

	no_repeat_deassert_a: assert property (@(posedge clock) disable iff (!rstn)
		legacy_deassert_s and clock_en |=> !(intx_req && !intx_assert))
		else $error("repeat deassert");

	assert_on_edge_a: assert property (@(posedge clock) disable iff (!rstn)
		legacy_assert_s |-> $past(edge_bus.rise)) else $error("assert without edge");

	pin_a_only_a: assert property (@(posedge clock) disable iff (!rstn)
		intx_req |-> intx_pin == intr_gen_pkg::pin_a_code) else $error("pin not A");

	// Link and partition
	link_negate_a: assert property (@(posedge clock) disable iff (!rstn)
		link_down && clock_en |=> !intx_wire) else $error("wire held on link down");

	link_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
		link_down && !edge_bus.wire_level && clock_en |=> !intx_req) else $error("req on dead link");

	// Condition sources and masking
	cond_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		clock_en && !cond_now |=> !cond_level) else $error("condition stuck");

	hp_source_a: assert property (@(posedge clock) disable iff (!rstn)
		hp_source_s |=> cond_level) else $error("hot-plug source lost");

	bw_source_a: assert property (@(posedge clock) disable iff (!rstn)
		st_reg.bw_notify && bw_live && clock_en |=> cond_level)
		else $error("bandwidth source lost");

	abw_source_a: assert property (@(posedge clock) disable iff (!rstn)
		st_reg.abw_notify && abw_live && clock_en |=> cond_level)
		else $error("autonomous bandwidth source lost");

	masked_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
		masked_all_s |=> !cond_level) else $error("condition while all masked");

	// Read data stands one cycle only, and a low enable freezes everything
	rdata_idle_a: assert property (@(posedge clock) disable iff (!rstn)
		!reg_read && clock_en |=> reg_rdata == 32'h0000_0000)
		else $error("read data held over");

	freeze_hold_a: assert property (@(posedge clock) disable iff (!rstn)
		!clock_en |=> $stable(cond_level) && $stable(intx_wire) && $stable(msi_req)
		&& $stable(intx_req) && $stable(reg_rdata)) else $error("state moved while frozen");
endmodule
`default_nettype wire

// *** rtl/intr_gen_pkg.sv ***
package intr_gen_pkg;
	// Register offsets of the block's own control and status words
	localparam logic [3:0] ctrl_offset      = 4'h0;
	localparam logic [3:0] status_offset    = 4'h1;
	localparam logic [3:0] addr_low_offset  = 4'h2;
	localparam logic [3:0] addr_high_offset = 4'h3;
	localparam logic [3:0] data_offset      = 4'h4;
	localparam logic [3:0] count_offset     = 4'h5;
	// Control word field positions, then bandwidth status bit positions
	localparam int msi_enable_bit    = 0;
	localparam int legacy_dis_bit    = 1;
	localparam int bw_notify_bit     = 2;
	localparam int abw_notify_bit    = 3;
	localparam int hp_enable_bit     = 4;
	localparam int bw_status_bit     = 0;
	localparam int abw_status_bit    = 1;
	// Reset values
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;
	localparam logic [31:0] addr_reset = 32'h0000_0000;
	localparam logic [15:0] data_reset = 16'h0000;
	// Legacy pin code: only pin A is ever used
	localparam logic [1:0] pin_a_code = 2'h0;
	// Interrupt message requests
	typedef enum logic [1:0] {
		req_none     = 2'b00,
		req_assert   = 2'b01,
		req_deassert = 2'b10,
		req_msi      = 2'b11
	} req_kind_type;
endpackage

// *** rtl/intr_req_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface intr_req_if;
	logic cond;
	logic msi_en;
	logic legacy_dis;
	logic link_down;
	logic rise;
	logic fall;
	logic wire_level;
	modport detect (input cond, msi_en, legacy_dis, link_down, output rise, fall, wire_level);
	modport top (output cond, msi_en, legacy_dis, link_down, input rise, fall, wire_level);
endinterface
`default_nettype wire

// *** rtl/intr_edge_detect.sv ***
`timescale 1ns/10ps
`default_nettype none
module intr_edge_detect (
	input  wire logic    clock,
	input  wire logic    rstn,
	input  wire logic    enable,
	intr_req_if.detect   bus
);
	typedef struct packed {
		logic cond_last;
		logic wire_on;
	} edge_state_type;

	edge_state_type st_reg;
	edge_state_type st_next;

	// Next state: remember level, track virtual wire
	always_comb begin
		st_next = st_reg;
		st_next.cond_last = bus.cond;
		if (bus.link_down) begin
			st_next.wire_on = 1'b0;
		end else if (bus.rise && !bus.msi_en && !bus.legacy_dis) begin
			st_next.wire_on = 1'b1;
		end else if (bus.fall) begin
			st_next.wire_on = 1'b0;
		end
	end

	// Register state
	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_reg <= '0;
		end else if (enable) begin
			st_reg <= st_next;
		end
	end

	// Transitions only, never level repeats
	assign bus.rise = bus.cond && !st_reg.cond_last && enable;
	assign bus.fall = !bus.cond && st_reg.cond_last && enable;
	assign bus.wire_level = st_reg.wire_on;
endmodule
`default_nettype wire

// *** test/intx_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module intx_core_model (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [3:0] ack_delay,
	input  wire logic       msi_req,
	input  wire logic       intx_req,
	input  wire logic       intx_assert,
	input  wire logic [1:0] intx_pin,
	output logic            msi_ack,
	output logic            agg_level,
	output int              asserts,
	output int              deasserts,
	output int              msis,
	output int              bad_pins
);
	logic [3:0] wait_reg;

	// Upstream path takes each MSI after a chosen delay
	always_ff @(posedge clock) begin
		if (!rstn || !msi_req || msi_ack) begin
			msi_ack <= 1'b0;
			wait_reg <= 4'h0;
		end else if (wait_reg == ack_delay) begin
			msi_ack <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end

	// Aggregate pin A state and tally every request
	always_ff @(posedge clock) begin
		if (!rstn) begin
			agg_level <= 1'b0;
			asserts <= 0;
			deasserts <= 0;
			msis <= 0;
			bad_pins <= 0;
		end else begin
			if (msi_req && msi_ack)
				msis <= msis + 1;
			if (intx_req && intx_assert) begin
				asserts <= asserts + 1;
				agg_level <= 1'b1;
			end
			if (intx_req && !intx_assert) begin
				deasserts <= deasserts + 1;
				agg_level <= 1'b0;
			end
			if (intx_req && intx_pin != 2'h0)
				bad_pins <= bad_pins + 1;
		end
	end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clock = 1'b0, rstn = 1'b0, clock_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [3:0] reg_addr = 4'h0, ack_delay = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
	logic hp = 1'b0, bw = 1'b0, abw = 1'b0, link_up = 1'b1, in_partition = 1'b1;
	logic msi_req, msi_ack, intx_req, intx_assert, intx_wire, cond_level, agg_level;
	logic [63:0] msi_addr;
	logic [15:0] msi_data;
	logic [1:0] intx_pin;
	int asserts, deasserts, msis, bad_pins, ea, ed, em, fail_count, comparisons, cycles;

	switch_port_interrupt_gen i_switch_port_interrupt_gen (.clock(clock), .rstn(rstn),
		.clock_en(clock_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.hotplug_intr(hp), .link_bw_mgmt_status(bw), .link_autonomous_bw_status(abw),
		.link_up(link_up), .in_partition(in_partition), .msi_req(msi_req),
		.msi_addr(msi_addr), .msi_data(msi_data), .msi_ack(msi_ack), .intx_req(intx_req),
		.intx_assert(intx_assert), .intx_pin(intx_pin), .intx_wire(intx_wire),
		.cond_level(cond_level));
	intx_core_model i_intx_core_model (.clock(clock), .rstn(rstn), .ack_delay(ack_delay),
		.msi_req(msi_req), .intx_req(intx_req), .intx_assert(intx_assert),
		.intx_pin(intx_pin), .msi_ack(msi_ack), .agg_level(agg_level), .asserts(asserts),
		.deasserts(deasserts), .msis(msis), .bad_pins(bad_pins));

	// Clock and hang guard
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			test_done();
		end
	end

	task test_done;
		if (fail_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task rd(input logic [3:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		rd_val = reg_rdata;
	endtask

	// Let inputs settle, then compare the far side's tallies and wire level
	task step(input int da, input int dd, input int dm, input logic w);
		repeat (12) @(posedge clock);
		ea += da;
		ed += dd;
		em += dm;
		check(asserts == ea && deasserts == ed && msis == em, "request counts");
		check(intx_wire === w && agg_level === w && intx_pin === 2'h0, "wire or pin");
	endtask

	task t_reset;
		wr(4'hf, 32'hffff_ffff);
		rd(4'hf);
		check(rd_val === 32'h0, "unmapped read");
		rd(intr_gen_pkg::ctrl_offset);
		check(rd_val === intr_gen_pkg::ctrl_reset, "ctrl reset");
		rd(intr_gen_pkg::status_offset);
		check(rd_val === 32'h20 && msi_req === 1'b0 && intx_req === 1'b0, "status reset");
		@(negedge clock);
		check(reg_rdata === 32'h0, "read data held over");
	endtask

	task t_legacy;
		wr(intr_gen_pkg::ctrl_offset, 32'h10);
		hp <= 1'b1;
		step(1, 0, 0, 1'b1);
		rd(intr_gen_pkg::status_offset);
		check(rd_val === 32'h3c && cond_level === 1'b1, "status raised");
		step(0, 0, 0, 1'b1);
		hp <= 1'b0;
		step(0, 1, 0, 1'b0);
		wr(intr_gen_pkg::ctrl_offset, 32'h12);
		hp <= 1'b1;
		step(0, 0, 0, 1'b0);
		hp <= 1'b0;
		step(0, 0, 0, 1'b0);
	endtask

	task t_mask;
		wr(intr_gen_pkg::ctrl_offset, 32'h04);
		bw <= 1'b1;
		abw <= 1'b1;
		step(1, 0, 0, 1'b1);
		wr(intr_gen_pkg::ctrl_offset, 32'h00);
		step(0, 1, 0, 1'b0);
		wr(intr_gen_pkg::ctrl_offset, 32'h08);
		step(1, 0, 0, 1'b1);
		abw <= 1'b0;
		step(0, 1, 0, 1'b0);
		bw <= 1'b0;
	endtask

	task t_msi;
		int n;
		wr(intr_gen_pkg::addr_low_offset, 32'hfee0_1000);
		wr(intr_gen_pkg::addr_high_offset, 32'h0000_00ab);
		wr(intr_gen_pkg::data_offset, 32'h0000_beef);
		for (int k = 0; k < 2; k++) begin
			ack_delay <= k ? 4'h6 : 4'h0;
			wr(intr_gen_pkg::ctrl_offset, k ? 32'h13 : 32'h11);
			hp <= 1'b1;
			n = 0;
			while (msi_req !== 1'b1 && n < 20) begin
				@(posedge clock);
				#1;
				n++;
			end
			check(msi_addr === 64'h0000_00ab_fee0_1000 && msi_data === 16'hbeef, "payload");
			step(0, 0, 1, 1'b0);
			hp <= 1'b0;
			step(0, 0, 0, 1'b0);
		end
		rd(intr_gen_pkg::count_offset);
		check(rd_val === 32'h2, "msi count");
	endtask

	task t_link;
		wr(intr_gen_pkg::ctrl_offset, 32'h10);
		for (int k = 0; k < 2; k++) begin
			hp <= 1'b1;
			step(1, 0, 0, 1'b1);
			if (k == 0)
				link_up <= 1'b0;
			else
				in_partition <= 1'b0;
			step(0, 1, 0, 1'b0);
			hp <= 1'b0;
			link_up <= 1'b1;
			in_partition <= 1'b1;
			step(0, 0, 0, 1'b0);
		end
		check(bad_pins == 0, "pin other than A");
	endtask

	task t_freeze;
		clock_en <= 1'b0;
		hp <= 1'b1;
		repeat (12) @(posedge clock);
		check(cond_level === 1'b0 && intx_wire === 1'b0 && asserts == ea, "moved while frozen");
		clock_en <= 1'b1;
		step(1, 0, 0, 1'b1);
		hp <= 1'b0;
		step(0, 1, 0, 1'b0);
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		t_reset();
		t_legacy();
		t_mask();
		t_msi();
		t_link();
		t_freeze();
		test_done();
	end
endmodule
`default_nettype wire
